// File: mem_map_pkg.sv
// Constants for the program and data memory address map of the 8-bit core.
package mem_map_pkg;

  // ---------------------------------------------------------------
  // Program memory
  // ---------------------------------------------------------------
  localparam int          PC_W          = 10;
  localparam logic [9:0]  VEC_RESET     = 10'h000;
  localparam logic [9:0]  VEC_SOFT_IRQ  = 10'h001;
  localparam logic [9:0]  VEC_HW_IRQ    = 10'h008;
  localparam int          STACK_DEPTH   = 8;
  localparam int          STACK_PTR_W   = 3;

  // ---------------------------------------------------------------
  // Register pages
  // ---------------------------------------------------------------
  localparam int          RADDR_W       = 6;
  localparam int          GPR_FIRST     = 16;
  localparam int          GPR_COUNT     = 48;
  localparam logic [5:0]  SFR_LAST      = 6'h0f;
  localparam int          BANK_HI       = 7;
  localparam int          BANK_LO       = 6;

  // R-page offsets.
  localparam logic [5:0]  R_INDIRECT_ACCESS_PORT = 6'h00;
  localparam logic [5:0]  R_TIMER0_COUNT         = 6'h01;
  localparam logic [5:0]  R_PROG_COUNTER_LOW     = 6'h02;
  localparam logic [5:0]  R_ALU_STATUS_FLAGS     = 6'h03;
  localparam logic [5:0]  R_INDIRECT_POINTER     = 6'h04;
  localparam logic [5:0]  R_PORT_B_DATA          = 6'h06;
  localparam logic [5:0]  R_POWER_CONTROL        = 6'h08;
  localparam logic [5:0]  R_PORT_B_DATA_WAKE_ENABLE    = 6'h09;
  localparam logic [5:0]  R_PROG_COUNTER_HIGH_BUF = 6'h0a;
  localparam logic [5:0]  R_PULL_LOW_CONTROL     = 6'h0b;
  localparam logic [5:0]  R_PULL_HIGH_CONTROL    = 6'h0c;
  localparam logic [5:0]  R_IRQ_ENABLE_MASK      = 6'h0e;
  localparam logic [5:0]  R_IRQ_FLAG_BITS        = 6'h0f;

  // F-page offsets.
  localparam logic [3:0]  F_PORT_DIRECTION_CONTROL = 4'h6;
  localparam logic [3:0]  F_PRESCALER0_VALUE       = 4'ha;
  localparam logic [3:0]  F_OPEN_DRAIN_CONTROL     = 4'hc;
  localparam logic [3:0]  F_POWER_CONTROL_EXT      = 4'hf;

  // S-page offsets.
  localparam logic [3:0]  S_TIMER1_COUNT        = 4'h0;
  localparam logic [3:0]  S_TIMER1_CONTROL_A    = 4'h1;
  localparam logic [3:0]  S_TIMER1_CONTROL_B    = 4'h2;
  localparam logic [3:0]  S_PWM_DUTY_CYCLE      = 4'h3;
  localparam logic [3:0]  S_PRESCALER1_VALUE    = 4'h4;
  localparam logic [3:0]  S_BUZZER_CONTROL      = 4'h5;
  localparam logic [3:0]  S_INFRARED_CARRIER_CTL = 4'h6;
  localparam logic [3:0]  S_TABLE_READ_HIGH_PTR = 4'h7;
  localparam logic [3:0]  S_TABLE_READ_HIGH_DATA = 4'h8;
  localparam logic [3:0]  S_OSCILLATOR_CONTROL  = 4'hf;

  // Reset values of the registers held here.
  localparam logic [7:0]  RST_INDIRECT_POINTER = 8'h00;
  localparam logic [7:0]  RST_PC_HIGH_BUF      = 8'h00;
  localparam logic [7:0]  RST_ZERO             = 8'h00;
  localparam logic [2:0]  RST_STACK_PTR        = 3'h0;

  // ---------------------------------------------------------------
  // Program-flow operations from the fetch and execute logic
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    FLOW_NEXT,
    FLOW_MEDIUM_JUMP,
    FLOW_SHORT_CALL,
    FLOW_PAGE_JUMP_ALT,
    FLOW_PAGE_SUBROUTINE_ALT,
    FLOW_LONG_JUMP,
    FLOW_LONG_SUBROUTINE_JUMP,
    FLOW_SUB_EXIT,
    FLOW_EXIT_WITH_LITERAL,
    FLOW_INTERRUPT_EXIT,
    FLOW_SOFT_IRQ,
    FLOW_HW_IRQ,
    FLOW_HOLD
  } flow_op_t;

  // Register page selected by the accessing instruction.
  typedef enum logic [1:0] {
    PAGE_R,
    PAGE_F,
    PAGE_S
  } page_t;

endpackage

// File: mem_address_map.sv
// Program counter, return stack and data-memory decoder of the 8-bit core.
`timescale 1ns/1ns
`default_nettype none

module mem_address_map
  import mem_map_pkg::*;
(
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             sys_rst,
  // Program flow from the execute stage
  input  wire flow_op_t         flow_op,
  input  wire logic [9:0]       flow_target,
  output logic      [9:0]       prog_counter,
  output logic      [2:0]       stack_level,
  // Data access from the execute stage
  input  wire page_t            acc_page,
  input  wire logic [5:0]       acc_opcode_addr,
  input  wire logic             acc_rd,
  input  wire logic             acc_wr,
  input  wire logic [7:0]       acc_wdata,
  output logic      [7:0]       acc_rdata,
  // Peripheral register port, decoded into flat page addresses
  output logic      [1:0]       periph_page,
  output logic      [3:0]       periph_addr,
  output logic                  periph_rd,
  output logic                  periph_wr,
  output logic      [7:0]       periph_wdata,
  input  wire logic [7:0]       periph_rdata,
  // Live pointer value
  output logic      [7:0]       indirect_pointer
);

  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  logic [9:0] pc_reg;
  logic [9:0] pc_next;
  logic [9:0] stack_mem [STACK_DEPTH];
  logic [2:0] sp_reg;
  logic [7:0] fsr_reg;
  logic [7:0] prog_counter_high_buffer_reg;
  logic [7:0] scratch_mem [GPR_COUNT];
  logic [9:0] pc_plus1;
  logic       push_en;
  logic       pop_en;
  logic [2:0] sp_top;

  assign pc_plus1 = pc_reg + 10'h001;
  assign sp_top   = sp_reg - 3'h1;

  // ---------------------------------------------------------------
  // Program counter
  // ---------------------------------------------------------------
  always_comb
  begin
    pc_next = pc_plus1;
    push_en = 1'b0;
    pop_en  = 1'b0;
    case (flow_op)
      FLOW_NEXT:
        pc_next = pc_plus1;
      FLOW_MEDIUM_JUMP:
        pc_next = {prog_counter_high_buffer_reg[1], flow_target[8:0]};
      FLOW_SHORT_CALL:
      begin
        pc_next = {prog_counter_high_buffer_reg[1:0], flow_target[7:0]};
        push_en = 1'b1;
      end
      FLOW_PAGE_JUMP_ALT:
        pc_next = {prog_counter_high_buffer_reg[1:0], flow_target[7:0]};
      FLOW_PAGE_SUBROUTINE_ALT:
      begin
        pc_next = {prog_counter_high_buffer_reg[1:0], flow_target[7:0]};
        push_en = 1'b1;
      end
      FLOW_LONG_JUMP:
        pc_next = flow_target;
      FLOW_LONG_SUBROUTINE_JUMP:
      begin
        pc_next = flow_target;
        push_en = 1'b1;
      end
      FLOW_SUB_EXIT, FLOW_EXIT_WITH_LITERAL, FLOW_INTERRUPT_EXIT:
      begin
        pc_next = stack_mem[sp_top];
        pop_en  = 1'b1;
      end
      FLOW_SOFT_IRQ:
      begin
        pc_next = VEC_SOFT_IRQ;
        push_en = 1'b1;
      end
      FLOW_HW_IRQ:
      begin
        pc_next = VEC_HW_IRQ;
        push_en = 1'b1;
      end
      FLOW_HOLD:
        pc_next = pc_reg;
      default:
        pc_next = pc_plus1;
    endcase
  end

  // Interrupt entry pushes the address of the instruction not yet run;
  // a call pushes the address after the calling instruction.
  logic [9:0] push_value;
  always_comb
  begin
    case (flow_op)
      FLOW_SOFT_IRQ, FLOW_HW_IRQ:
        push_value = pc_reg;
      default:
        push_value = pc_plus1;
    endcase
  end

  // Direct writes to the low counter byte take the high bits from the buffer.
  logic pcl_write;

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      pc_reg <= VEC_RESET;
    else if (pcl_write)
      pc_reg <= {prog_counter_high_buffer_reg[1:0], acc_wdata};
    else
      pc_reg <= pc_next;
  end

  // ---------------------------------------------------------------
  // Return stack
  // ---------------------------------------------------------------
  // A direct write to the low counter byte replaces the flow step, so the
  // stack stays put in that cycle.
  logic push_go;
  logic pop_go;
  assign push_go = push_en && !pcl_write && !sys_rst;
  assign pop_go  = pop_en && !pcl_write;

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      sp_reg <= RST_STACK_PTR;
    else if (push_go)
      sp_reg <= sp_reg + 3'h1;
    else if (pop_go)
      sp_reg <= sp_top;
  end

  always_ff @(posedge sys_clk)
  begin
    if (push_go)
      stack_mem[sp_reg] <= push_value;
  end

  // ---------------------------------------------------------------
  // Data address decode
  // ---------------------------------------------------------------
  logic [5:0] r_addr;
  logic       r_sel;
  logic       is_gpr;
  logic [5:0] gpr_idx;

  logic [1:0] bank_select;
  assign bank_select = fsr_reg[BANK_HI:BANK_LO];

  logic [7:0] bank_addr;
  assign bank_addr = (acc_opcode_addr == R_INDIRECT_ACCESS_PORT) ?
                     {bank_select, fsr_reg[5:0]} : {bank_select, acc_opcode_addr};
  assign r_addr = bank_addr[5:0];
  assign r_sel   = (acc_page == PAGE_R);
  assign is_gpr  = (r_addr > SFR_LAST);
  assign gpr_idx = r_addr - 6'(GPR_FIRST);

  // ---------------------------------------------------------------
  // Registers held in this block
  // ---------------------------------------------------------------
  logic r_wr;
  logic scratch_wr;
  logic fsr_wr;
  logic prog_counter_high_buffer_wr;

  // Reset blocks every write, so a strobe left high cannot land in it.
  assign r_wr       = r_sel && acc_wr && !sys_rst;
  assign scratch_wr = r_wr && is_gpr;
  assign fsr_wr     = r_wr && (r_addr == R_INDIRECT_POINTER);
  assign prog_counter_high_buffer_wr  = r_wr && (r_addr == R_PROG_COUNTER_HIGH_BUF);
  assign pcl_write  = r_wr && (r_addr == R_PROG_COUNTER_LOW);

  always_ff @(posedge sys_clk)
  begin
    if (scratch_wr)
      scratch_mem[gpr_idx] <= acc_wdata;
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      fsr_reg <= RST_INDIRECT_POINTER;
    else if (fsr_wr)
      fsr_reg <= acc_wdata;
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      prog_counter_high_buffer_reg <= RST_PC_HIGH_BUF;
    else if (prog_counter_high_buffer_wr)
      prog_counter_high_buffer_reg <= acc_wdata;
  end

  // Bank-0 special registers outside this block go to the peripheral port.
  logic r_ext;
  always_comb
  begin
    case (r_addr)
      R_TIMER0_COUNT, R_ALU_STATUS_FLAGS, R_PORT_B_DATA, R_POWER_CONTROL,
      R_PORT_B_DATA_WAKE_ENABLE, R_PULL_LOW_CONTROL, R_PULL_HIGH_CONTROL,
      R_IRQ_ENABLE_MASK, R_IRQ_FLAG_BITS:
        r_ext = 1'b1;
      default:
        r_ext = 1'b0;
    endcase
  end

  logic       pg_ext;
  logic [3:0] pg_addr;
  assign pg_addr = acc_opcode_addr[3:0];
  always_comb
  begin
    pg_ext = 1'b0;
    if (acc_page == PAGE_F)
    begin
      case (pg_addr)
        F_PORT_DIRECTION_CONTROL, F_PRESCALER0_VALUE, F_OPEN_DRAIN_CONTROL,
        F_POWER_CONTROL_EXT:
          pg_ext = 1'b1;
        default:
          pg_ext = 1'b0;
      endcase
    end
    else if (acc_page == PAGE_S)
    begin
      case (pg_addr)
        S_TIMER1_COUNT, S_TIMER1_CONTROL_A, S_TIMER1_CONTROL_B, S_PWM_DUTY_CYCLE,
        S_PRESCALER1_VALUE, S_BUZZER_CONTROL, S_INFRARED_CARRIER_CTL,
        S_TABLE_READ_HIGH_PTR, S_TABLE_READ_HIGH_DATA, S_OSCILLATOR_CONTROL:
          pg_ext = 1'b1;
        default:
          pg_ext = 1'b0;
      endcase
    end
  end

  logic ext_hit;
  assign ext_hit = (r_sel && !is_gpr && r_ext) || pg_ext;

  assign periph_rd    = ext_hit && acc_rd;
  assign periph_wr    = ext_hit && acc_wr;
  assign periph_page  = r_sel ? 2'(PAGE_R) : 2'(acc_page);
  assign periph_addr  = r_sel ? r_addr[3:0] : pg_addr;
  assign periph_wdata = acc_wdata;

  // ---------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------
  // zero for unmapped reads
  always_comb
  begin
    acc_rdata = RST_ZERO;
    if (ext_hit)
      acc_rdata = periph_rdata;
    else if (r_sel && is_gpr)
      acc_rdata = scratch_mem[gpr_idx];
    else if (r_sel)
    begin
      case (r_addr)
        R_PROG_COUNTER_LOW:      acc_rdata = pc_reg[7:0];
        R_INDIRECT_POINTER:      acc_rdata = fsr_reg;
        R_PROG_COUNTER_HIGH_BUF: acc_rdata = prog_counter_high_buffer_reg;
        default:                 acc_rdata = RST_ZERO;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // ten-bit counter out
  assign prog_counter     = pc_reg;
  assign stack_level      = sp_reg;
  assign indirect_pointer = fsr_reg;

endmodule // mem_address_map

`default_nettype wire

// File: mem_address_map_props.sv
// Concurrent checks on the ports of the address map block.
`timescale 1ns/1ns
`default_nettype none
module mem_address_map_props
  import mem_map_pkg::*;
(
  // Clock and reset
  input wire logic       sys_clk,
  input wire logic       sys_rst,
  // Program flow
  input wire flow_op_t   flow_op,
  input wire logic [9:0] flow_target,
  input wire logic [9:0] prog_counter,
  input wire logic [2:0] stack_level,
  // Data access
  input wire page_t      acc_page,
  input wire logic [5:0] acc_opcode_addr,
  input wire logic       acc_rd,
  input wire logic       acc_wr,
  input wire logic [7:0] acc_wdata,
  input wire logic [7:0] acc_rdata,
  input wire logic [1:0] periph_page,
  input wire logic [3:0] periph_addr,
  input wire logic       periph_rd,
  input wire logic       periph_wr,
  input wire logic [7:0] periph_wdata,
  input wire logic [7:0] indirect_pointer
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  wire call_op = flow_op inside {FLOW_SHORT_CALL, FLOW_PAGE_SUBROUTINE_ALT,
    FLOW_LONG_SUBROUTINE_JUMP, FLOW_SOFT_IRQ, FLOW_HW_IRQ};
  wire ret_op = flow_op inside {FLOW_SUB_EXIT, FLOW_EXIT_WITH_LITERAL, FLOW_INTERRUPT_EXIT};
  a_reset_fetch: assert property ($fell(sys_rst) |-> prog_counter == 10'h000)
    else $error("pc not zero after reset");
  a_soft_vector: assert property (!acc_wr && flow_op == FLOW_SOFT_IRQ |=> prog_counter == 10'h001)
    else $error("soft irq vector wrong");
  a_hw_vector: assert property (!acc_wr && flow_op == FLOW_HW_IRQ |=> prog_counter == 10'h008)
    else $error("hw irq vector wrong");
  a_short_reach: assert property (!acc_wr &&
    flow_op inside {FLOW_SHORT_CALL, FLOW_PAGE_JUMP_ALT, FLOW_PAGE_SUBROUTINE_ALT}
    |=> prog_counter[7:0] == $past(flow_target[7:0]))
    else $error("short target wrong");
  a_medium_reach: assert property (!acc_wr && flow_op == FLOW_MEDIUM_JUMP
    |=> prog_counter[8:0] == $past(flow_target[8:0]))
    else $error("medium target wrong");
  a_long_reach: assert property (!acc_wr &&
    flow_op inside {FLOW_LONG_JUMP, FLOW_LONG_SUBROUTINE_JUMP}
    |=> prog_counter == $past(flow_target))
    else $error("long target wrong");
  a_push_level: assert property (!acc_wr && call_op |=> stack_level == $past(stack_level) + 3'd1)
    else $error("push level wrong");
  a_pop_level: assert property (!acc_wr && ret_op |=> stack_level == $past(stack_level) - 3'd1)
    else $error("pop level wrong");
  a_pointer_load: assert property (acc_wr && acc_page == PAGE_R
    && acc_opcode_addr == 6'h04 |=> indirect_pointer == $past(acc_wdata))
    else $error("pointer not loaded");
  a_fpage_decode: assert property (acc_rd && acc_page == PAGE_F
    && acc_opcode_addr[3:0] == 4'h6
    |-> periph_rd && periph_page == 2'd1 && periph_addr == 4'h6)
    else $error("f page decode wrong");
  a_unmapped_quiet: assert property (acc_page == PAGE_R
    && acc_opcode_addr == 6'h05 && acc_rd |-> !periph_rd && acc_rdata == 8'h00)
    else $error("unmapped access leaked");
  a_wdata_pass: assert property (acc_wr && acc_page == PAGE_R && acc_opcode_addr == 6'h01
    |-> periph_wr && periph_page == 2'd0 && periph_addr == 4'h1 && periph_wdata == acc_wdata)
    else $error("timer write not passed on");
endmodule // mem_address_map_props
bind mem_address_map mem_address_map_props mem_address_map_props_i (.sys_clk, .sys_rst,
  .flow_op, .flow_target, .prog_counter, .stack_level, .acc_page, .acc_opcode_addr, .acc_rd,
  .acc_wr, .acc_wdata, .acc_rdata, .periph_page, .periph_addr, .periph_rd, .periph_wr,
  .periph_wdata, .indirect_pointer);
`default_nettype wire

// File: mem_address_map_bench.sv
// Self-checking testbench for the address map block.
`timescale 1ns/1ns
`default_nettype none
module mem_address_map_bench;
  import mem_map_pkg::*;
  logic sys_clk = 0, sys_rst = 1, acc_rd = 0, acc_wr = 0, periph_rd, periph_wr;
  flow_op_t flow_op = FLOW_HOLD;
  page_t acc_page = PAGE_R;
  logic [9:0] flow_target = 0, prog_counter;
  logic [5:0] acc_opcode_addr = 0;
  logic [7:0] acc_wdata = 0, periph_rdata = 8'ha6, acc_rdata, periph_wdata, indirect_pointer;
  logic [2:0] stack_level;
  logic [1:0] periph_page;
  logic [3:0] periph_addr;
  int err_total = 0, samples_checked = 0;
  mem_address_map mem_address_map_i (.sys_clk(sys_clk), .sys_rst(sys_rst), .flow_op(flow_op),
    .flow_target(flow_target), .prog_counter(prog_counter), .stack_level(stack_level),
    .acc_page(acc_page), .acc_opcode_addr(acc_opcode_addr), .acc_rd(acc_rd), .acc_wr(acc_wr),
    .acc_wdata(acc_wdata), .acc_rdata(acc_rdata), .periph_page(periph_page),
    .periph_addr(periph_addr), .periph_rd(periph_rd), .periph_wr(periph_wr),
    .periph_wdata(periph_wdata), .periph_rdata(periph_rdata),
    .indirect_pointer(indirect_pointer));
  initial forever #4 sys_clk = ~sys_clk;
  task close_out;
    $display("mismatches %0d of %0d compares", err_total, samples_checked);
    if (err_total == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input logic [9:0] seen, input logic [9:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task drv(input flow_op_t op, input logic [9:0] t, input page_t p, input logic [5:0] a,
           input logic rd, input logic wr, input logic [7:0] d);
    @(posedge sys_clk);
    flow_op <= op;
    flow_target <= t;
    acc_page <= p;
    acc_opcode_addr <= a;
    acc_rd <= rd;
    acc_wr <= wr;
    acc_wdata <= d;
    #1;
  endtask
  task wr(input page_t p, input logic [5:0] a, input logic [7:0] d);
    drv(FLOW_HOLD, 0, p, a, 0, 1, d);
  endtask
  task rd(input page_t p, input logic [5:0] a, input logic [7:0] e);
    drv(FLOW_HOLD, 0, p, a, 1, 0, 0);
    chk(10'(acc_rdata), 10'(e));
  endtask
  task fc(input flow_op_t op, input logic [9:0] t, input logic [9:0] e, input logic [2:0] l);
    drv(op, t, PAGE_R, 0, 0, 0, 0);
    drv(FLOW_HOLD, 0, PAGE_R, 0, 0, 0, 0);
    chk(prog_counter, e);
    chk(10'(stack_level), 10'(l));
  endtask
  task pp(input page_t p, input logic [5:0] a, input logic hit);
    drv(FLOW_HOLD, 0, p, a, 1, 0, 0);
    chk(10'(periph_rd), 10'(hit));
    chk(10'(acc_rdata), hit ? 10'h0a6 : 10'h000);
    if (hit)
      chk(10'({periph_page, periph_addr}), 10'({2'(p), a[3:0]}));
    drv(FLOW_HOLD, 0, p, a, 0, 1, 8'h5b);
    chk(10'(periph_wr), 10'(hit));
    chk(10'(periph_wdata), 10'h05b);
  endtask
  // ---------------------------------------------------------------
  // Test sequence
  // ---------------------------------------------------------------
  initial
  begin
    repeat (4) @(posedge sys_clk);
    sys_rst <= 0;
    #1;
    chk(prog_counter, 10'h000);
    fc(FLOW_NEXT, 0, 10'h001, 0);
    fc(FLOW_LONG_SUBROUTINE_JUMP, 10'h3fd, 10'h3fd, 1);
    fc(FLOW_SUB_EXIT, 0, 10'h002, 0);
    wr(PAGE_R, R_PROG_COUNTER_HIGH_BUF, 8'h03);
    fc(FLOW_MEDIUM_JUMP, 10'h0ff, 10'h2ff, 0);
    fc(FLOW_SHORT_CALL, 10'h1ab, 10'h3ab, 1);
    fc(FLOW_PAGE_JUMP_ALT, 10'h055, 10'h355, 1);
    fc(FLOW_PAGE_SUBROUTINE_ALT, 10'h0cc, 10'h3cc, 2);
    fc(FLOW_EXIT_WITH_LITERAL, 0, 10'h356, 1);
    fc(FLOW_INTERRUPT_EXIT, 0, 10'h300, 0);
    fc(FLOW_HW_IRQ, 0, 10'h008, 1);
    fc(FLOW_SOFT_IRQ, 0, 10'h001, 2);
    fc(FLOW_INTERRUPT_EXIT, 0, 10'h008, 1);
    fc(FLOW_INTERRUPT_EXIT, 0, 10'h300, 0);
    for (int i = 0; i < 9; i++)
      fc(FLOW_LONG_SUBROUTINE_JUMP, 10'h040 + 10'(i), 10'h040 + 10'(i), 3'(i + 1));
    fc(FLOW_SUB_EXIT, 0, 10'h048, 0);
    fc(FLOW_SUB_EXIT, 0, 10'h047, 7);
    fc(FLOW_LONG_JUMP, 10'h2a5, 10'h2a5, 7);
    wr(PAGE_R, R_PROG_COUNTER_LOW, 8'h40);
    drv(FLOW_HOLD, 0, PAGE_R, 0, 0, 0, 0);
    chk(prog_counter, 10'h340);
    wr(PAGE_R, R_INDIRECT_POINTER, 8'hd5);
    rd(PAGE_R, R_INDIRECT_POINTER, 8'hd5);
    chk(10'(indirect_pointer), 10'h0d5);
    wr(PAGE_R, 6'h15, 8'h3c);
    rd(PAGE_R, R_INDIRECT_ACCESS_PORT, 8'h3c);
    wr(PAGE_R, R_INDIRECT_ACCESS_PORT, 8'h77);
    rd(PAGE_R, 6'h15, 8'h77);
    rd(PAGE_R, R_PROG_COUNTER_HIGH_BUF, 8'h03);
    for (int b = 0; b < 4; b++)
    begin
      wr(PAGE_R, R_INDIRECT_POINTER, {2'(b), 6'h3f});
      wr(PAGE_R, R_INDIRECT_ACCESS_PORT, 8'h10 + 8'(b));
      rd(PAGE_R, 6'h3f, 8'h10 + 8'(b));
    end
    pp(PAGE_R, 6'h01, 1);
    pp(PAGE_R, 6'h05, 0);
    pp(PAGE_F, 6'h06, 1);
    pp(PAGE_F, 6'h00, 0);
    pp(PAGE_F, 6'h0f, 1);
    pp(PAGE_S, 6'h08, 1);
    pp(PAGE_S, 6'h0f, 1);
    pp(PAGE_S, 6'h09, 0);
    @(posedge sys_clk);
    sys_rst <= 1;
    @(posedge sys_clk);
    sys_rst <= 0;
    #1;
    chk(prog_counter, 10'h000);
    chk(10'(stack_level), 10'h000);
    chk(10'(indirect_pointer), 10'h000);
    repeat (2) @(posedge sys_clk);
    close_out;
  end
  initial
  begin
    repeat (2000) @(posedge sys_clk);
    err_total++;
    close_out;
  end
endmodule // mem_address_map_bench
`default_nettype wire
